// ===== potg_pkg.sv
/*
 * potg_pkg: constants, register map and types for the two-port gpio block.
 * assumes an 8-bit register view carried in the low byte of a 32-bit bus word.
 */
package potg_pkg;

   // register byte offsets
   localparam logic [7:0] POTG_OFF_P1_DIR   = 8'h00;
   localparam logic [7:0] POTG_OFF_P1_LATCH = 8'h04;
   localparam logic [7:0] POTG_OFF_P1_PU    = 8'h08;
   localparam logic [7:0] POTG_OFF_P2_DIR   = 8'h0C;
   localparam logic [7:0] POTG_OFF_MODE     = 8'h10;
   localparam logic [7:0] POTG_OFF_P2_LATCH = 8'h14;

   // reset values
   localparam logic [7:0] POTG_RST_P1_DIR   = 8'h00;
   localparam logic [7:0] POTG_RST_P1_LATCH = 8'h00;
   localparam logic [7:0] POTG_RST_P1_PU    = 8'h00;
   localparam logic [7:0] POTG_RST_P2_DIR   = 8'h00;
   localparam logic [7:0] POTG_RST_MODE     = 8'h00;
   localparam logic [7:0] POTG_RST_P2_LATCH = 8'h00;

   // implemented bits and read-as-one bits
   localparam logic [7:0] POTG_P1_PIN_MASK  = 8'hF7;
   localparam logic [7:0] POTG_P1_RSV_ONES  = 8'h08;
   localparam logic [7:0] POTG_P2_PIN_MASK  = 8'h07;
   localparam logic [7:0] POTG_P2_RSV_ONES  = 8'hF8;
   localparam logic [7:0] POTG_MODE_RW_MASK = 8'h96;
   localparam logic [7:0] POTG_MODE_RD_ONES = 8'h08;

   // mode register field positions
   localparam int POTG_MODE_PIN7_ALT_BIT = 7;
   localparam int POTG_MODE_PIN4_ALT_BIT = 4;
   localparam int POTG_MODE_TXD_BIT  = 1;

   // port pin positions with alternate use
   localparam int POTG_P1_PIN_SEVEN = 7;
   localparam int POTG_P1_PIN_FOUR  = 4;
   localparam int POTG_P2_PIN_TWO   = 2;
   localparam int POTG_P2_PIN_ONE   = 1;
   localparam int POTG_P2_PIN_ZERO  = 0;

   // bus responses
   localparam logic [1:0] POTG_RESP_OKAY   = 2'b00;
   localparam logic [1:0] POTG_RESP_SLVERR = 2'b10;

   typedef enum {POTG_WR_GATHER, POTG_WR_ANSWER} potg_wr_state_t;
   typedef enum {POTG_RD_IDLE, POTG_RD_ANSWER} potg_rd_state_t;

endpackage

// ===== potg_cfg_if.sv
/*
 * potg_cfg_if: configuration from the register file to the pin logic,
 * and synchronised pin levels back. assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface potg_cfg_if;
   logic [7:0] p1_dir;
   logic [7:0] p1_latch;
   logic [7:0] p1_pu;
   logic [7:0] p2_dir;
   logic [7:0] p2_latch;
   logic [7:0] mode;
   logic [7:0] p1_level;
   logic [7:0] p2_level;

   modport regs (output p1_dir, p1_latch, p1_pu, p2_dir, p2_latch, mode,
                 input  p1_level, p2_level);
   modport pins (input  p1_dir, p1_latch, p1_pu, p2_dir, p2_latch, mode,
                 output p1_level, p2_level);
endinterface

// ===== potg_pin_ctrl.sv
/*
 * potg_pin_ctrl: pin synchronisers, direction and alternate function
 * muxing for both ports, pull-up for port 1. assumes pin inputs are asynchronous
 * and serial controls come from logic on the same clock.
 */
`timescale 1ns/1ps
module potg_pin_ctrl
   import potg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   potg_cfg_if.pins        cfg,
   input  wire logic [7:0] p1_in,
   input  wire logic [7:0] p2_in,
   output logic      [7:0] p1_out,
   output logic      [7:0] p1_oe,
   output logic      [7:0] p1_pu,
   output logic      [7:0] p2_out,
   output logic      [7:0] p2_oe,
   input  wire logic       ser_txd,
   input  wire logic       ser_rx_en,
   input  wire logic       ser_clk_out_en,
   input  wire logic       ser_clk_out,
   input  wire logic       ser_clk_in_en,
   output logic            ext_int_three_n,
   output logic            timer_trigger,
   output logic            ext_int_zero_n,
   output logic            ser_rxd,
   output logic            ser_clk_in
);

   logic [7:0] s1_1_r, s1_2_r, s1_3_r, lvl1_r;
   logic [7:0] s2_1_r, s2_2_r, s2_3_r, lvl2_r;
   logic [7:0] alt1;
   logic [7:0] oe2_nxt, out2_nxt;

   // a level moves only once the two later stages agree, so glitches are dropped
   function automatic logic [7:0] settle(input logic [7:0] old, input logic [7:0] a,
                                         input logic [7:0] b);
      logic [7:0] agree;
      agree  = ~(a ^ b);
      settle = (b & agree) | (old & ~agree);
   endfunction

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_1_r <= 8'h00; s1_2_r <= 8'h00; s1_3_r <= 8'h00; lvl1_r <= 8'h00;
         s2_1_r <= 8'h00; s2_2_r <= 8'h00; s2_3_r <= 8'h00; lvl2_r <= 8'h00;
      end
      else
      begin
         s1_1_r <= p1_in & POTG_P1_PIN_MASK;
         s1_2_r <= s1_1_r;
         s1_3_r <= s1_2_r;
         lvl1_r <= settle(lvl1_r, s1_2_r, s1_3_r);
         s2_1_r <= p2_in & POTG_P2_PIN_MASK;
         s2_2_r <= s2_1_r;
         s2_3_r <= s2_2_r;
         lvl2_r <= settle(lvl2_r, s2_2_r, s2_3_r);
      end
   end

   assign cfg.p1_level = lvl1_r;
   assign cfg.p2_level = lvl2_r;

   always_comb
   begin
      alt1 = 8'h00;
      alt1[POTG_P1_PIN_SEVEN] = cfg.mode[POTG_MODE_PIN7_ALT_BIT];
      alt1[POTG_P1_PIN_FOUR]  = cfg.mode[POTG_MODE_PIN4_ALT_BIT];
   end

   // serial and mode selections override the direction bit
   always_comb
   begin
      oe2_nxt  = cfg.p2_dir & POTG_P2_PIN_MASK;
      out2_nxt = cfg.p2_latch & POTG_P2_PIN_MASK;
      if (cfg.mode[POTG_MODE_TXD_BIT])
      begin
         oe2_nxt[POTG_P2_PIN_TWO]  = 1'b1;
         out2_nxt[POTG_P2_PIN_TWO] = ser_txd;
      end
      if (ser_rx_en)
         oe2_nxt[POTG_P2_PIN_ONE] = 1'b0;
      if (ser_clk_in_en)
         oe2_nxt[POTG_P2_PIN_ZERO] = 1'b0;
      else if (ser_clk_out_en)
      begin
         oe2_nxt[POTG_P2_PIN_ZERO]  = 1'b1;
         out2_nxt[POTG_P2_PIN_ZERO] = ser_clk_out;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p1_out <= 8'h00;
         p1_oe  <= 8'h00;
         p1_pu  <= 8'h00;
      end
      else
      begin
         p1_out <= cfg.p1_latch & POTG_P1_PIN_MASK;
         p1_oe  <= cfg.p1_dir & ~alt1 & POTG_P1_PIN_MASK;
         p1_pu  <= cfg.p1_pu & ~cfg.p1_dir & POTG_P1_PIN_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p2_out <= 8'h00;
         p2_oe  <= 8'h00;
      end
      else
      begin
         p2_out <= out2_nxt;
         p2_oe  <= oe2_nxt;
      end
   end

   // idle levels: interrupts inactive high, receive line at mark
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_int_three_n <= 1'b1;
         timer_trigger   <= 1'b0;
         ext_int_zero_n  <= 1'b1;
         ser_rxd         <= 1'b1;
         ser_clk_in      <= 1'b0;
      end
      else
      begin
         ext_int_three_n <= alt1[POTG_P1_PIN_SEVEN] ? lvl1_r[POTG_P1_PIN_SEVEN] : 1'b1;
         timer_trigger   <= alt1[POTG_P1_PIN_SEVEN] & lvl1_r[POTG_P1_PIN_SEVEN];
         ext_int_zero_n  <= alt1[POTG_P1_PIN_FOUR] ? lvl1_r[POTG_P1_PIN_FOUR] : 1'b1;
         ser_rxd         <= ser_rx_en ? lvl2_r[POTG_P2_PIN_ONE] : 1'b1;
         ser_clk_in      <= ser_clk_in_en & lvl2_r[POTG_P2_PIN_ZERO];
      end
   end

endmodule

// ===== potg_top.sv
/*
 * potg_top: register file and AXI4-Lite slave for two gpio ports,
 * with the pin logic in potg_pin_ctrl.
 * assumes one clock, pins arriving asynchronously, and a bus master that
 * keeps at most one write and one read outstanding.
 */
`timescale 1ns/1ps
module potg_top
   import potg_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic [2:0]  S_AXI_AWPROT,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic [2:0]  S_AXI_ARPROT,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [7:0]  P1_IN,
   output logic      [7:0]  P1_OUT,
   output logic      [7:0]  P1_OE,
   output logic      [7:0]  P1_PULLUP_EN,
   input  wire logic [2:0]  P2_IN,
   output logic      [2:0]  P2_OUT,
   output logic      [2:0]  P2_OE,
   output logic             EXT_INT_THREE_N,
   output logic             TIMER_TRIGGER_IN,
   output logic             EXT_INT_ZERO_N,
   input  wire logic        SER_TXD,
   input  wire logic        SER_RX_EN,
   output logic             SER_RXD,
   input  wire logic        SER_CLK_OUT_EN,
   input  wire logic        SER_CLK_OUT,
   input  wire logic        SER_CLK_IN_EN,
   output logic             SER_CLK_IN
);

   potg_cfg_if cfg_bus ();

   potg_wr_state_t wr_state_r;
   potg_rd_state_t rd_state_r;

   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   logic [7:0]  w_data_r;
   logic        w_lane0_r;
   logic [1:0]  bresp_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        wr_go;
   logic        aw_take;
   logic        w_take;
   logic        ar_take;

   logic [7:0]  p1_dir_r;
   logic [7:0]  p1_latch_r;
   logic [7:0]  p1_pu_r;
   logic [7:0]  p2_dir_r;
   logic [7:0]  p2_latch_r;
   logic [7:0]  mode_r;

   logic [7:0]  p2_out_full;
   logic [7:0]  p2_oe_full;
   logic [7:0]  p2_in_full;

   // address match on the whole byte address: unaligned offsets stay unmapped
   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == POTG_OFF_P1_DIR)   || (addr == POTG_OFF_P1_LATCH) ||
               (addr == POTG_OFF_P1_PU)    || (addr == POTG_OFF_P2_DIR)   ||
               (addr == POTG_OFF_MODE)     || (addr == POTG_OFF_P2_LATCH);
   endfunction

   // stored bit where driving, pin level where listening
   function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] level, input logic [7:0] mask,
                                           input logic [7:0] ones);
      mix_read = (((dir & latch) | (~dir & level)) & mask) | ones;
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         POTG_OFF_P1_LATCH:
            v = mix_read(p1_dir_r, p1_latch_r, cfg_bus.p1_level,
                         POTG_P1_PIN_MASK, POTG_P1_RSV_ONES);
         POTG_OFF_P1_PU:
            v = (p1_pu_r & POTG_P1_PIN_MASK) | POTG_P1_RSV_ONES;
         POTG_OFF_MODE:
            v = (mode_r & POTG_MODE_RW_MASK) | POTG_MODE_RD_ONES;
         POTG_OFF_P2_LATCH:
            v = mix_read(p2_dir_r, p2_latch_r, cfg_bus.p2_level,
                         POTG_P2_PIN_MASK, POTG_P2_RSV_ONES);
         default:
            v = 8'h00; // direction registers are write-only and read as zero
      endcase
      reg_read = v;
   endfunction

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_go && w_lane0_r && (aw_addr_r == off);
   endfunction

   // bus handshakes
   assign S_AXI_AWREADY = (wr_state_r == POTG_WR_GATHER) && !aw_held_r;
   assign S_AXI_WREADY  = (wr_state_r == POTG_WR_GATHER) && !w_held_r;
   assign S_AXI_BVALID  = (wr_state_r == POTG_WR_ANSWER);
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = (rd_state_r == POTG_RD_IDLE);
   assign S_AXI_RVALID  = (rd_state_r == POTG_RD_ANSWER);
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;

   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take  = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   // write lands one edge after both halves are held, keeping decode off the bus path
   assign wr_go   = (wr_state_r == POTG_WR_GATHER) && aw_held_r && w_held_r;

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end
      else if (aw_take)
      begin
         aw_held_r <= 1'b1;
         aw_addr_r <= S_AXI_AWADDR;
      end
      else if (wr_go)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         w_held_r  <= 1'b0;
         w_data_r  <= 8'h00;
         w_lane0_r <= 1'b0;
      end
      else if (w_take)
      begin
         w_held_r  <= 1'b1;
         w_data_r  <= S_AXI_WDATA[7:0];
         w_lane0_r <= S_AXI_WSTRB[0];
      end
      else if (wr_go)
         w_held_r <= 1'b0;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_state_r <= POTG_WR_GATHER;
         bresp_r    <= POTG_RESP_OKAY;
      end
      else
      begin
         case (wr_state_r)
            POTG_WR_GATHER:
               if (wr_go)
               begin
                  wr_state_r <= POTG_WR_ANSWER;
                  bresp_r    <= mapped(aw_addr_r) ? POTG_RESP_OKAY : POTG_RESP_SLVERR;
               end
            POTG_WR_ANSWER:
               if (S_AXI_BREADY)
                  wr_state_r <= POTG_WR_GATHER;
            default:
               wr_state_r <= POTG_WR_GATHER;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_state_r <= POTG_RD_IDLE;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= POTG_RESP_OKAY;
      end
      else
      begin
         case (rd_state_r)
            POTG_RD_IDLE:
               if (ar_take)
               begin
                  rd_state_r <= POTG_RD_ANSWER;
                  rdata_r    <= {24'h00_0000, reg_read(S_AXI_ARADDR)};
                  rresp_r    <= mapped(S_AXI_ARADDR) ? POTG_RESP_OKAY : POTG_RESP_SLVERR;
               end
            POTG_RD_ANSWER:
               if (S_AXI_RREADY)
                  rd_state_r <= POTG_RD_IDLE;
            default:
               rd_state_r <= POTG_RD_IDLE;
         endcase
      end
   end

   // registers, each on its own
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         p1_dir_r <= POTG_RST_P1_DIR;
      else if (wr_hit(POTG_OFF_P1_DIR))
         p1_dir_r <= w_data_r & POTG_P1_PIN_MASK;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         p1_latch_r <= POTG_RST_P1_LATCH;
      else if (wr_hit(POTG_OFF_P1_LATCH))
         p1_latch_r <= w_data_r & POTG_P1_PIN_MASK;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         p1_pu_r <= POTG_RST_P1_PU;
      else if (wr_hit(POTG_OFF_P1_PU))
         p1_pu_r <= w_data_r & POTG_P1_PIN_MASK;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         p2_dir_r <= POTG_RST_P2_DIR;
      else if (wr_hit(POTG_OFF_P2_DIR))
         p2_dir_r <= w_data_r & POTG_P2_PIN_MASK;
   end

   // reserved mode bit 2 is kept writable, software must leave it clear
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         mode_r <= POTG_RST_MODE;
      else if (wr_hit(POTG_OFF_MODE))
         mode_r <= w_data_r & POTG_MODE_RW_MASK;
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         p2_latch_r <= POTG_RST_P2_LATCH;
      else if (wr_hit(POTG_OFF_P2_LATCH))
         p2_latch_r <= w_data_r & POTG_P2_PIN_MASK;
   end

   assign cfg_bus.p1_dir   = p1_dir_r;
   assign cfg_bus.p1_latch = p1_latch_r;
   assign cfg_bus.p1_pu    = p1_pu_r;
   assign cfg_bus.p2_dir   = p2_dir_r;
   assign cfg_bus.p2_latch = p2_latch_r;
   assign cfg_bus.mode     = mode_r;

   assign p2_in_full = {5'h00, P2_IN};
   assign P2_OUT     = p2_out_full[2:0];
   assign P2_OE      = p2_oe_full[2:0];

   potg_pin_ctrl u_pins
   (
      .clk             (REF_CLK),
      .rst_n           (RST_N),
      .cfg             (cfg_bus.pins),
      .p1_in           (P1_IN),
      .p2_in           (p2_in_full),
      .p1_out          (P1_OUT),
      .p1_oe           (P1_OE),
      .p1_pu           (P1_PULLUP_EN),
      .p2_out          (p2_out_full),
      .p2_oe           (p2_oe_full),
      .ser_txd         (SER_TXD),
      .ser_rx_en       (SER_RX_EN),
      .ser_clk_out_en  (SER_CLK_OUT_EN),
      .ser_clk_out     (SER_CLK_OUT),
      .ser_clk_in_en   (SER_CLK_IN_EN),
      .ext_int_three_n (EXT_INT_THREE_N),
      .timer_trigger   (TIMER_TRIGGER_IN),
      .ext_int_zero_n  (EXT_INT_ZERO_N),
      .ser_rxd         (SER_RXD),
      .ser_clk_in      (SER_CLK_IN)
   );

endmodule

// ===== potg_pin_model.sv
/* potg_pin_model: the pads outside both ports, with an outside level per pin.
   assumes driven pins win and the pull-up beats an undriven outside level. */
`timescale 1ns/1ps
module potg_pin_model (
   input  wire logic [7:0] p1_oe,
   input  wire logic [7:0] p1_out,
   input  wire logic [7:0] p1_pu,
   input  wire logic [7:0] ext1,
   input  wire logic [2:0] p2_oe,
   input  wire logic [2:0] p2_out,
   input  wire logic [2:0] ext2,
   output logic      [7:0] p1_pin,
   output logic      [2:0] p2_pin
);
   // weak pull-up only shows on pins nobody drives
   assign p1_pin = (p1_oe & p1_out) | (~p1_oe & (p1_pu | ext1));
   assign p2_pin = (p2_oe & p2_out) | (~p2_oe & ext2);
endmodule

// ===== potg_top_asserts.sv
/* potg_top_asserts: checks on the ports of potg_top.
   assumes one clock domain, bound into every potg_top. */
`timescale 1ns/1ps
module potg_top_asserts
   import potg_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [7:0]  P1_OUT,
   input wire logic [7:0]  P1_OE,
   input wire logic [7:0]  P1_PULLUP_EN,
   input wire logic [2:0]  P2_OE,
   input wire logic        EXT_INT_THREE_N,
   input wire logic        TIMER_TRIGGER_IN,
   input wire logic        EXT_INT_ZERO_N,
   input wire logic        SER_RX_EN
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   pu_vs_drive_a: assert property ((P1_PULLUP_EN & P1_OE) == 8'h00)
      else $error("pull-up on a driven pin");
   rsv_bit_a: assert property (!P1_OE[3] && !P1_PULLUP_EN[3] && !P1_OUT[3])
      else $error("reserved pin active");
   pin7_gpio_a: assert property (P1_OE[7] && $past(P1_OE[7]) |-> EXT_INT_THREE_N && !TIMER_TRIGGER_IN)
      else $error("pin 7 alternate input while driving");
   pin4_gpio_a: assert property (P1_OE[4] && $past(P1_OE[4]) |-> EXT_INT_ZERO_N)
      else $error("pin 4 alternate input while driving");
   rx_release_a: assert property (SER_RX_EN [*3] |-> !P2_OE[1])
      else $error("receive pin still driven");
   b_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID) else $error("write answer late");
   r_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer dropped");
   aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while answer pending");
   cover property (!EXT_INT_THREE_N);
   cover property (S_AXI_RVALID && S_AXI_RRESP == POTG_RESP_SLVERR);
   cover property (|P1_PULLUP_EN);
endmodule
bind potg_top potg_top_asserts chk_i (.REF_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .P1_OUT, .P1_OE,
   .P1_PULLUP_EN, .P2_OE, .EXT_INT_THREE_N, .TIMER_TRIGGER_IN, .EXT_INT_ZERO_N, .SER_RX_EN);

// ===== tb_potg_top.sv
/* tb_potg_top: random configurations checked against a register model.
   assumes the pad model and the bound checker. */
`timescale 1ns/1ps
module tb_potg_top
   import potg_pkg::*;
;
   logic        REF_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        S_AXI_RREADY, EXT_INT_THREE_N, TIMER_TRIGGER_IN, EXT_INT_ZERO_N, SER_TXD;
   logic        SER_RX_EN, SER_RXD, SER_CLK_OUT_EN, SER_CLK_OUT, SER_CLK_IN_EN, SER_CLK_IN;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, P1_IN, P1_OUT, P1_OE, P1_PULLUP_EN, ext1;
   logic [2:0]  S_AXI_AWPROT, S_AXI_ARPROT, P2_IN, P2_OUT, P2_OE, ext2;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [7:0]  m_dir, m_lat, m_pu, m_mode, m_p2d, m_p2l;
   integer      failures = 0, checks = 0, seed = 49;

   potg_top uut (.REF_CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWPROT, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .P1_IN, .P1_OUT, .P1_OE, .P1_PULLUP_EN, .P2_IN,
      .P2_OUT, .P2_OE, .EXT_INT_THREE_N, .TIMER_TRIGGER_IN, .EXT_INT_ZERO_N, .SER_TXD, .SER_RX_EN,
      .SER_RXD, .SER_CLK_OUT_EN, .SER_CLK_OUT, .SER_CLK_IN_EN, .SER_CLK_IN);
   potg_pin_model pm (.p1_oe(P1_OE), .p1_out(P1_OUT), .p1_pu(P1_PULLUP_EN), .ext1,
      .p2_oe(P2_OE), .p2_out(P2_OUT), .ext2, .p1_pin(P1_IN), .p2_pin(P2_IN));

   initial
   begin
      REF_CLK = 1'h0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // slow answer taking now and then, so the answer must stand
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw, w;
      aw = 1'h1;
      w = 1'h1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h00_0000, d};
      S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      while (aw || w)
      begin
         @(posedge REF_CLK);
         if (aw && S_AXI_AWREADY)
         begin
            aw = 1'h0;
            S_AXI_AWVALID <= 1'h0;
         end
         if (w && S_AXI_WREADY)
         begin
            w = 1'h0;
            S_AXI_WVALID <= 1'h0;
         end
      end
      repeat ($random(seed) & 3) @(posedge REF_CLK);
      S_AXI_BREADY <= 1'h1;
      do @(posedge REF_CLK); while (S_AXI_BVALID !== 1'h1);
      S_AXI_BREADY <= 1'h0;
      chk("bresp", er, S_AXI_BRESP);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'h1);
      S_AXI_ARVALID <= 1'h0;
      repeat ($random(seed) & 3) @(posedge REF_CLK);
      S_AXI_RREADY <= 1'h1;
      do @(posedge REF_CLK); while (S_AXI_RVALID !== 1'h1);
      S_AXI_RREADY <= 1'h0;
      chk("rdata", {24'h00_0000, e}, S_AXI_RDATA);
      chk("rresp", er, S_AXI_RRESP);
   endtask

   task automatic pins();
      logic [7:0] o1, u1, q1;
      logic [2:0] o2, d2, q2;
      o1 = m_dir & POTG_P1_PIN_MASK & ~{m_mode[7], 2'h0, m_mode[4], 4'h0};
      u1 = m_pu & POTG_P1_PIN_MASK & ~m_dir;
      q1 = (o1 & m_lat) | (~o1 & (u1 | ext1));
      o2 = {m_mode[1] | m_p2d[2], m_p2d[1] & ~SER_RX_EN,
            ~SER_CLK_IN_EN & (SER_CLK_OUT_EN | m_p2d[0])};
      d2 = {m_mode[1] ? SER_TXD : m_p2l[2], m_p2l[1],
            (SER_CLK_OUT_EN & ~SER_CLK_IN_EN) ? SER_CLK_OUT : m_p2l[0]};
      q2 = (o2 & d2) | (~o2 & ext2);
      chk("p1_oe", o1, P1_OE);
      chk("p1_out", m_lat & POTG_P1_PIN_MASK, P1_OUT);
      chk("p1_pu", u1, P1_PULLUP_EN);
      chk("p2_oe", o2, P2_OE);
      chk("p2_out", d2, P2_OUT);
      chk("int_three", m_mode[7] ? q1[7] : 1'h1, EXT_INT_THREE_N);
      chk("trig", m_mode[7] & q1[7], TIMER_TRIGGER_IN);
      chk("int_zero", m_mode[4] ? q1[4] : 1'h1, EXT_INT_ZERO_N);
      chk("rxd", SER_RX_EN ? q2[1] : 1'h1, SER_RXD);
      chk("sck", SER_CLK_IN_EN & q2[0], SER_CLK_IN);
      rd(POTG_OFF_P1_DIR, 8'h00, POTG_RESP_OKAY);
      rd(POTG_OFF_P1_LATCH, (((m_dir & m_lat) | (~m_dir & q1)) & 8'hF7) | 8'h08,
         POTG_RESP_OKAY);
      rd(POTG_OFF_P1_PU, (m_pu & 8'hF7) | 8'h08, POTG_RESP_OKAY);
      rd(POTG_OFF_P2_DIR, 8'h00, POTG_RESP_OKAY);
      rd(POTG_OFF_MODE, (m_mode & 8'h96) | 8'h08, POTG_RESP_OKAY);
      rd(POTG_OFF_P2_LATCH, {5'h1F, (m_p2d[2:0] & m_p2l[2:0]) | (~m_p2d[2:0] & q2)},
         POTG_RESP_OKAY);
   endtask

   initial
   begin
      RST_N = 1'h0;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_AWPROT, S_AXI_ARPROT} = '0;
      {SER_TXD, SER_RX_EN, SER_CLK_OUT_EN, SER_CLK_OUT, SER_CLK_IN_EN} = '0;
      {m_dir, m_lat, m_pu, m_mode, m_p2d, m_p2l} = '0;
      S_AXI_WSTRB = 4'h1;
      ext1 = 8'h5A;
      ext2 = 3'h5;
      repeat (20) @(posedge REF_CLK);
      RST_N <= 1'h1;
      repeat (10) @(posedge REF_CLK);
      pins();
      $display("test reset_values done");
      rd(8'h18, 8'h00, POTG_RESP_SLVERR);
      rd(8'h05, 8'h00, POTG_RESP_SLVERR);
      wr(8'h18, 8'hFF, 4'h1, POTG_RESP_SLVERR);
      wr(POTG_OFF_P1_LATCH, 8'hFF, 4'h0, POTG_RESP_OKAY);
      repeat (10) @(posedge REF_CLK);
      pins();
      $display("test refusals done");
      for (int i = 0; i < 24; i++)
      begin
         {SER_TXD, SER_RX_EN, SER_CLK_OUT_EN, SER_CLK_OUT, SER_CLK_IN_EN} <= 5'($random(seed));
         ext1 <= 8'($random(seed));
         ext2 <= 3'($random(seed));
         m_dir = 8'($random(seed));
         m_lat = 8'($random(seed));
         m_pu = 8'($random(seed));
         m_mode = 8'($random(seed)) & 8'h96;
         m_p2d = 8'($random(seed));
         m_p2l = 8'($random(seed));
         wr(POTG_OFF_P1_DIR, m_dir, 4'h1, POTG_RESP_OKAY);
         wr(POTG_OFF_P1_LATCH, m_lat, 4'h1, POTG_RESP_OKAY);
         wr(POTG_OFF_P1_PU, m_pu, 4'h1, POTG_RESP_OKAY);
         wr(POTG_OFF_MODE, m_mode, 4'h1, POTG_RESP_OKAY);
         wr(POTG_OFF_P2_DIR, m_p2d, 4'h1, POTG_RESP_OKAY);
         wr(POTG_OFF_P2_LATCH, m_p2l, 4'h1, POTG_RESP_OKAY);
         repeat (10) @(posedge REF_CLK);
         pins();
      end
      $display("test random_config done");
      RST_N <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'h1;
      {m_dir, m_lat, m_pu, m_mode, m_p2d, m_p2l} = '0;
      repeat (10) @(posedge REF_CLK);
      pins();
      $display("test second_reset done");
      stop_test();
   end

   // about 1400 cycles expected; generous margin
   initial
   begin
      repeat (30000) @(posedge REF_CLK);
      failures++;
      stop_test();
   end
endmodule
